// ### common/ufit_regs.vh
// Purpose: constants for the frame interval timer
// Assumes: 32-bit register port, byte offsets as printed
// Notes:   definitions only
//
// What this block does
// R1: 14-bit period field reloads frame countdown
// R2: reset gives period 11999, others zero
// R3: packet budget loaded at each frame start
// R4: budget counter bounds bits per transaction
// R5: software computes and writes packet budget
// R6: software flips toggle on each period write
// R7: software may trim period every frame
// R8: software saves period before controller reset
// R9: countdown decrements once per bit time
// R10: at zero, reload period next bit time
// R11: at zero, copy period toggle to countdown
// R12: entering running state reloads the countdown
// R13: software writes reserved bits as zero
// R14: each reload marks a new frame start
`ifndef UFIT_REGS_VH
`define UFIT_REGS_VH
`define UFIT_ADDR_W        8
`define UFIT_OFS_PERIOD    8'h34
`define UFIT_OFS_COUNTDOWN 8'h38
`define UFIT_PERIOD_W      14
`define UFIT_PKT_W         15
`define UFIT_PERIOD_LSB    0
`define UFIT_PKT_LSB       16
`define UFIT_TOGGLE_BIT    31
`define UFIT_PERIOD_RST    14'h2EDF
`define UFIT_PKT_RST       15'h0000
`define UFIT_BIT_DIV       16'h0008
`endif

// ### verilog/ufit_down_counter.v
// Purpose: loadable down counter with zero flag
// Assumes: load wins over decrement
// Notes:   stops at zero unless reloaded
`timescale 1ns/100ps
module ufit_down_counter #(
  parameter W = 14
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         load,
  input  wire [W-1:0] load_val,
  input  wire         dec,
  output wire [W-1:0] count,
  output wire         is_zero
);
  reg [W-1:0] cnt_q;
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= {W{1'b0}};
    end else if (load) begin
      cnt_q <= load_val;
    end else if (dec && (cnt_q != {W{1'b0}})) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign count   = cnt_q;
  assign is_zero = (cnt_q == {W{1'b0}});
endmodule // ufit_down_counter

// ### verilog/ufit_frame_timer.v
// Purpose: frame length, countdown and packet budget of a full-speed host
// Assumes: registers reached by a simple word port; bit time from divider
// Notes:   countdown waits at zero until the next bit time reloads it
`timescale 1ns/100ps
`include "ufit_regs.vh"
module ufit_frame_timer #(
  parameter [15:0] BIT_DIV = `UFIT_BIT_DIV
) (
  input  wire        CLK_SYS,
  input  wire        SYS_RST,
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [7:0]  REG_ADDR,
  input  wire [31:0] REG_WDATA,
  output reg  [31:0] REG_RDATA,
  input  wire        BUS_RUNNING_STATE,
  input  wire        PKT_BITS_USED,
  output wire        FRAME_START,
  output wire [13:0] BIT_TIME_LEFT,
  output wire [14:0] MAX_PACKET_BITS,
  output wire        COUNTDOWN_TOGGLE
);
////////////////////////////////////////////////////////////////////////////////
  reg  [13:0] sof_period_q;
  reg  [14:0] max_pkt_q;
  reg         period_update_toggle_q;
  reg         countdown_toggle_q;
  reg  [14:0] pkt_left_q;
  reg  [15:0] div_q;
  reg         run_q;
  reg         frame_start_q;
  wire        bit_tick;
  wire        fr_zero;
  wire [13:0] fr_count;
  wire        run_enter;
  wire        fr_load;
  wire        wr_period;
  wire        wr_count;
////////////////////////////////////////////////////////////////////////////////
  // bit time enable from the system clock
  assign bit_tick = (div_q == BIT_DIV - 16'h0001);
  always @(posedge CLK_SYS) begin
    if (SYS_RST || bit_tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
////////////////////////////////////////////////////////////////////////////////
  assign wr_period = REG_WR && (REG_ADDR == `UFIT_OFS_PERIOD);
  assign wr_count  = REG_WR && (REG_ADDR == `UFIT_OFS_COUNTDOWN);
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sof_period_q           <= `UFIT_PERIOD_RST; // see R2
      max_pkt_q              <= `UFIT_PKT_RST;    // see R2
      period_update_toggle_q <= 1'b0;
    end else if (wr_period) begin
      sof_period_q           <= REG_WDATA[13:0];  // see R1
      max_pkt_q              <= REG_WDATA[30:16]; // see R5
      period_update_toggle_q <= REG_WDATA[`UFIT_TOGGLE_BIT];
    end
  end
////////////////////////////////////////////////////////////////////////////////
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      run_q <= 1'b0;
    end else begin
      run_q <= BUS_RUNNING_STATE;
    end
  end
  assign run_enter = BUS_RUNNING_STATE && !run_q;
  // reload on entry to running state or at a zero bit time
  assign fr_load = run_enter || (run_q && bit_tick && fr_zero); // see R10 R12

  ufit_down_counter #(
    .W (`UFIT_PERIOD_W)
  ) u_countdown (
    .clk      (CLK_SYS),
    .rst      (SYS_RST),
    .load     (fr_load || wr_count),
    .load_val (wr_count && !fr_load ? REG_WDATA[13:0] : sof_period_q), // see R1
    .dec      (run_q && bit_tick), // see R9
    .count    (fr_count),
    .is_zero  (fr_zero)
  );
////////////////////////////////////////////////////////////////////////////////
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      countdown_toggle_q <= 1'b0;
      pkt_left_q         <= 15'h0000;
      frame_start_q      <= 1'b0;
    end else begin
      frame_start_q <= fr_load; // see R14
      if (fr_load) begin
        pkt_left_q <= max_pkt_q; // see R3
      end else if (PKT_BITS_USED && pkt_left_q != 15'h0000) begin
        pkt_left_q <= pkt_left_q - 15'h0001; // see R4
      end
      if (run_q && bit_tick && fr_zero) begin
        countdown_toggle_q <= period_update_toggle_q; // see R11
      end else if (wr_count) begin
        countdown_toggle_q <= REG_WDATA[`UFIT_TOGGLE_BIT];
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      REG_RDATA <= 32'h00000000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `UFIT_OFS_PERIOD:
          REG_RDATA <= {period_update_toggle_q, max_pkt_q, 2'b00,
                        sof_period_q};
        `UFIT_OFS_COUNTDOWN:
          REG_RDATA <= {countdown_toggle_q, 17'h00000, fr_count};
        default:
          REG_RDATA <= 32'h00000000;
      endcase
    end
  end

  assign FRAME_START      = frame_start_q;
  assign BIT_TIME_LEFT    = fr_count;
  assign MAX_PACKET_BITS  = pkt_left_q;
  assign COUNTDOWN_TOGGLE = countdown_toggle_q;
endmodule // ufit_frame_timer

// ### bench/ufit_chk.sv
// Purpose: checker for ufit_frame_timer
// Assumes: one clock, sync reset
// Notes:   bound at the foot
`timescale 1ns/100ps
module ufit_chk #(
  parameter [15:0] BIT_DIV = 16'h0008
) (
  input wire        CLK_SYS,
  input wire        SYS_RST,
  input wire        REG_WR,
  input wire        REG_RD,
  input wire [7:0]  REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire [31:0] REG_RDATA,
  input wire        BUS_RUNNING_STATE,
  input wire        PKT_BITS_USED,
  input wire        FRAME_START,
  input wire [13:0] BIT_TIME_LEFT,
  input wire [14:0] MAX_PACKET_BITS,
  input wire        COUNTDOWN_TOGGLE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence reload_s;
    $past(BIT_TIME_LEFT) == 14'h0 && BIT_TIME_LEFT != 14'h0 &&
    !$past(REG_WR);
  endsequence
  a_reset_zero: assert property ($fell(SYS_RST) |->
    BIT_TIME_LEFT == 14'h0 && !COUNTDOWN_TOGGLE) else $error("reset");
  a_reload_start: assert property (reload_s |-> FRAME_START)
    else $error("no frame start");
  a_start_pulse: assert property (FRAME_START |=> !FRAME_START)
    else $error("long frame start");
  a_step_one: assert property ($changed(BIT_TIME_LEFT) &&
    $past(BIT_TIME_LEFT) != 14'h0 && $past(BUS_RUNNING_STATE, 2) &&
    !$past(REG_WR) |-> BIT_TIME_LEFT == $past(BIT_TIME_LEFT) - 14'h1)
    else $error("bad step");
  a_toggle_zero: assert property ($changed(COUNTDOWN_TOGGLE) &&
    !$past(REG_WR) |-> $past(BIT_TIME_LEFT) == 14'h0)
    else $error("toggle off zero");
  a_idle_hold: assert property (!BUS_RUNNING_STATE &&
    !$past(BUS_RUNNING_STATE) && !$past(BUS_RUNNING_STATE, 2) &&
    !$past(REG_WR) |-> $stable(BIT_TIME_LEFT))
    else $error("count while idle");
  a_rdata_hold: assert property (!$past(REG_RD) |-> $stable(REG_RDATA))
    else $error("read data moved");
  a_budget_step: assert property ($changed(MAX_PACKET_BITS) |->
    MAX_PACKET_BITS == $past(MAX_PACKET_BITS) - 15'h1 ||
    FRAME_START) else $error("budget jump");
endmodule // ufit_chk
bind ufit_frame_timer ufit_chk #(.BIT_DIV(BIT_DIV)) chk (
  .CLK_SYS           (CLK_SYS),
  .SYS_RST           (SYS_RST),
  .REG_WR            (REG_WR),
  .REG_RD            (REG_RD),
  .REG_ADDR          (REG_ADDR),
  .REG_WDATA         (REG_WDATA),
  .REG_RDATA         (REG_RDATA),
  .BUS_RUNNING_STATE (BUS_RUNNING_STATE),
  .PKT_BITS_USED     (PKT_BITS_USED),
  .FRAME_START       (FRAME_START),
  .BIT_TIME_LEFT     (BIT_TIME_LEFT),
  .MAX_PACKET_BITS   (MAX_PACKET_BITS),
  .COUNTDOWN_TOGGLE  (COUNTDOWN_TOGGLE)
);

// ### bench/tb_ufit_frame_timer.sv
// Purpose: self-checking bench for ufit_frame_timer
// Assumes: BIT_DIV of 2
// Notes:   reads checked from a queue
`timescale 1ns/100ps
module tb_ufit_frame_timer;
  reg CLK_SYS = 0, SYS_RST = 1, REG_WR = 0, REG_RD = 0, rv = 0;
  reg BUS_RUNNING_STATE = 0, PKT_BITS_USED = 0;
  reg [7:0] REG_ADDR = 8'h00;
  reg [31:0] REG_WDATA = 32'h0, p, b;
  wire [31:0] REG_RDATA;
  wire FRAME_START, COUNTDOWN_TOGGLE;
  wire [13:0] BIT_TIME_LEFT;
  wire [14:0] MAX_PACKET_BITS;
  logic [31:0] q[$];
  int n_mismatch = 0, n_compared = 0;
  time t0;
  ufit_frame_timer #(.BIT_DIV(16'h0002)) dut (
    .CLK_SYS           (CLK_SYS),
    .SYS_RST           (SYS_RST),
    .REG_WR            (REG_WR),
    .REG_RD            (REG_RD),
    .REG_ADDR          (REG_ADDR),
    .REG_WDATA         (REG_WDATA),
    .REG_RDATA         (REG_RDATA),
    .BUS_RUNNING_STATE (BUS_RUNNING_STATE),
    .PKT_BITS_USED     (PKT_BITS_USED),
    .FRAME_START       (FRAME_START),
    .BIT_TIME_LEFT     (BIT_TIME_LEFT),
    .MAX_PACKET_BITS   (MAX_PACKET_BITS),
    .COUNTDOWN_TOGGLE  (COUNTDOWN_TOGGLE)
  );
  always #5 CLK_SYS = ~CLK_SYS;
  task automatic chk(input [31:0] g, x);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic acc(input w, input [7:0] a, input [31:0] d);
    @(negedge CLK_SYS);
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, d};
    if (!w) q.push_back(d);
    @(negedge CLK_SYS);
    {REG_WR, REG_RD} = 2'b00;
  endtask
  task fs;
    do @(negedge CLK_SYS); while (FRAME_START !== 1'b1);
  endtask
  task conclude;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge CLK_SYS) rv <= REG_RD;
  always @(negedge CLK_SYS) if (rv) chk(REG_RDATA, q.pop_front());
  initial begin
    void'($urandom(32'h3BDA));
    repeat (16) @(negedge CLK_SYS);
    SYS_RST = 0;
    acc(0, 8'h34, 32'h0000_2EDF);
    acc(0, 8'h38, 32'h0);
    acc(0, 8'h3C, 32'h0);
    p = $urandom % 20 + 3;
    b = $urandom % 100 + 2;
    acc(1, 8'h34, {1'b1, b[14:0], 2'b00, p[13:0]});
    acc(0, 8'h34, {1'b1, b[14:0], 2'b00, p[13:0]});
    BUS_RUNNING_STATE = 1;
    fs;
    chk(MAX_PACKET_BITS, b);
    chk(BIT_TIME_LEFT, p);
    PKT_BITS_USED = 1;
    @(negedge CLK_SYS);
    PKT_BITS_USED = 0;
    chk(MAX_PACKET_BITS, b - 1);
    fs;
    t0 = $time;
    fs;
    chk(($time - t0) / 10, (p + 1) * 2);
    chk(COUNTDOWN_TOGGLE, 1);
    p = p + 2;
    acc(1, 8'h34, {1'b0, b[14:0], 2'b00, p[13:0]});
    fs;
    t0 = $time;
    fs;
    chk(($time - t0) / 10, (p + 1) * 2);
    chk(COUNTDOWN_TOGGLE, 0);
    acc(0, 8'h34, {1'b0, b[14:0], 2'b00, p[13:0]});
    @(negedge CLK_SYS);
    {SYS_RST, BUS_RUNNING_STATE} = 2'b10;
    repeat (4) @(negedge CLK_SYS);
    SYS_RST = 0;
    acc(0, 8'h34, 32'h0000_2EDF);
    acc(1, 8'h34, {1'b0, b[14:0], 2'b00, p[13:0]});
    acc(0, 8'h34, {1'b0, b[14:0], 2'b00, p[13:0]});
    acc(1, 8'h38, 32'h8000_0005);
    acc(0, 8'h38, 32'h8000_0005);
    conclude;
  end
  initial begin
    #100000;
    n_mismatch++;
    conclude;
  end
endmodule // tb_ufit_frame_timer
